// ---- design/cbcc_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbcc_device (
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	cbcc_if.dev             bus,
	input  wire logic       hit_i,
	input  wire logic       cacheable_i,
	input  wire logic       one_wait_i,
	input  wire logic       single_bank_i,
	input  wire logic       parity_en_i,
	input  wire logic [3:0] parity_i,
	input  wire logic       copro_fault_i,
	input  wire logic       cycle_done_i,
	input  wire logic       fill_we_i,
	input  wire logic       tag_update_i,
	input  wire logic [7:0] tag_new_i,
	input  wire logic       dram_phase_i,
	input  wire logic [7:0] dram_addr_i,
	input  wire logic       dma_grant_i,
	input  wire logic       dma_start_i,
	input  wire logic       dma16_i,
	input  wire logic       dma_wr_i,
	input  wire logic       dma_mem_i,
	input  wire logic [1:0] at_sa_i,
	input  wire logic       at_at_byte_high_enable_n_i,
	input  wire logic [7:0] xd_i,
	input  wire logic       dma_astb_i,
	output logic [3:0]      addr_lo_o,
	output logic [7:0]      tag_o,
	output logic [3:0]      parity_o,
	output logic            legacy_o,
	output logic            local_o
);
	cbcc_pkg::cbcc_state_t st;
	logic [2:0] busy_s;
	logic [2:0] done_s;
	logic [1:0] strap_cnt;
	logic       mode_set;
	logic       ext_done;
	logic [1:0] beat;
	logic [1:0] nb;
	logic       a2;
	logic       a3;
	logic       wr_l;
	logic       hit_l;
	logic [7:0] ma_l;
	logic [7:0] xd_l;
	logic       start;
	logic       rhit;
	logic       burst_end;
	logic       bank2;

	assign start     = (st == cbcc_pkg::ST_IDLE) && !bus.ads_n && bus.dma_oe_n;
	assign rhit      = hit_l && !wr_l && !legacy_o;
	assign burst_end = (st == cbcc_pkg::ST_BURST) && !bus.burst_ack_n
		&& (!bus.burst_final_indicator_n || (beat == cbcc_pkg::BEAT_LAST)); // RL3
	assign nb        = ((st == cbcc_pkg::ST_BURST || st == cbcc_pkg::ST_T2A) && !bus.burst_ack_n && !legacy_o)
		? beat + 2'h1 : beat;
	assign bank2     = a2 ^ nb[0];

	// ****************************************
	// Pin synchronisers and mode strap
	// ****************************************
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			busy_s   <= cbcc_pkg::SYNC_ZERO;
			done_s   <= cbcc_pkg::SYNC_ONE;
			mode_set <= 1'h0;
			legacy_o <= 1'h0;
			ext_done <= 1'h0;
			strap_cnt <= 2'h0;
		end
		else
		begin
			busy_s <= {busy_s[1:0], bus.busy_n};
			done_s <= {done_s[1:0], bus.done_in_n};
			// Strap only trusted once the chain holds real pin samples
			if (strap_cnt != cbcc_pkg::STRAP_WAIT)
				strap_cnt <= strap_cnt + 2'h1;
			else if (!mode_set && (busy_s[1] == busy_s[2]))
			begin
				legacy_o <= busy_s[1]; // RL23
				mode_set <= 1'h1;
			end
			if (done_s[1] == done_s[2])
				ext_done <= !done_s[2]; // RL13
		end
	end

	// ****************************************
	// Cycle sequencer
	// ****************************************
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			st <= cbcc_pkg::ST_IDLE;
		else
		begin
			unique case (st)
				cbcc_pkg::ST_IDLE:
					if (start)
						st <= cbcc_pkg::ST_T2A;
				cbcc_pkg::ST_T2A:
					if (!bus.local_device_claim_n)
						st <= cbcc_pkg::ST_LOCAL; // RL10
					else if ((!bus.burst_ack_n && !legacy_o) || (rhit && one_wait_i))
						st <= cbcc_pkg::ST_BURST;
					else
						st <= cbcc_pkg::ST_WAIT;
				cbcc_pkg::ST_BURST:
					if (burst_end)
						st <= cbcc_pkg::ST_IDLE;
				cbcc_pkg::ST_WAIT:
					if (cycle_done_i || ext_done)
						st <= cbcc_pkg::ST_IDLE;
				cbcc_pkg::ST_LOCAL:
					if (!bus.rdy_n)
						st <= cbcc_pkg::ST_IDLE; // RL12
				default:
					st <= cbcc_pkg::ST_IDLE;
			endcase
		end
	end

	// Address latch, beat count, claim
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			a2        <= 1'h0;
			a3        <= 1'h0;
			wr_l      <= 1'h0;
			hit_l     <= 1'h0;
			beat      <= cbcc_pkg::BEAT_ZERO;
			addr_lo_o <= 4'h0;
			ma_l      <= 8'h0;
			local_o   <= 1'h0;
		end
		else if (start)
		begin
			a2        <= bus.ca_lo[2];
			a3        <= bus.ca_lo[3];
			wr_l      <= bus.wr;
			hit_l     <= hit_i;
			beat      <= cbcc_pkg::BEAT_ZERO;
			addr_lo_o <= bus.ca_lo; // RL5
			ma_l      <= dram_addr_i; // RL19
			local_o   <= 1'h0;
		end
		else
		begin
			beat <= nb;
			if (st == cbcc_pkg::ST_T2A)
				local_o <= !bus.local_device_claim_n; // RL10
		end
	end

	// ****************************************
	// Processor handshake pins
	// ****************************************
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			bus.burst_ack_n <= 1'h1;
		else if (legacy_o)
			bus.burst_ack_n <= bus.burst_final_indicator_n; // RL4
		else if (start && hit_i && !bus.wr && !one_wait_i)
			bus.burst_ack_n <= 1'h0; // RL22
		else if (st == cbcc_pkg::ST_T2A && !bus.local_device_claim_n)
			bus.burst_ack_n <= 1'h1;
		else if (st == cbcc_pkg::ST_T2A && rhit && one_wait_i)
			bus.burst_ack_n <= 1'h0; // RL22
		else if (burst_end)
			bus.burst_ack_n <= 1'h1; // RL3
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			bus.ken_n <= 1'h0;
		else if (legacy_o)
			bus.ken_n <= !copro_fault_i; // RL9
		else if (start)
			bus.ken_n <= 1'h1; // RL8
		else if (st == cbcc_pkg::ST_T2A)
			bus.ken_n <= !cacheable_i; // RL8
		else if (st == cbcc_pkg::ST_IDLE)
			bus.ken_n <= 1'h0; // RL8
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus.rdy_d_n    <= 1'h1;
			bus.rdy_d_oe_n <= 1'h0;
		end
		else
		begin
			bus.rdy_d_n <= !(st == cbcc_pkg::ST_WAIT && (cycle_done_i || ext_done)); // RL13
			if (st == cbcc_pkg::ST_T2A && !bus.local_device_claim_n)
				bus.rdy_d_oe_n <= 1'h1; // RL12
			else if (st != cbcc_pkg::ST_LOCAL)
				bus.rdy_d_oe_n <= 1'h0;
		end
	end

	// ****************************************
	// Cache bank control
	// ****************************************
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus.ba_oe_n <= 1'h1;
			bus.ea3     <= 1'h0;
			bus.oa3     <= 1'h0;
			bus.eoe_n   <= 1'h1;
			bus.ooe_n   <= 1'h1;
		end
		else if (st == cbcc_pkg::ST_IDLE)
		begin
			bus.ba_oe_n <= 1'h1; // RL15
			bus.eoe_n   <= 1'h1;
			bus.ooe_n   <= 1'h1;
		end
		else
		begin
			bus.ba_oe_n <= 1'h0; // RL15
			bus.ea3     <= a3 ^ nb[1]; // RL15
			bus.oa3     <= single_bank_i ? bank2 : a3 ^ nb[1]; // RL16
			bus.eoe_n   <= !(hit_l && !wr_l) || bank2; // RL17
			bus.ooe_n   <= !(hit_l && !wr_l) || !bank2; // RL18
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus.c3s_n      <= 1'h1;
			bus.cwe_n      <= cbcc_pkg::CWE_NONE;
			bus.tag_store_write_n    <= 1'h1;
			bus.tag_d      <= 8'h0;
			bus.tag_d_oe_n <= 1'h1;
			tag_o          <= 8'h0;
		end
		else
		begin
			bus.c3s_n <= !start; // RL19
			if (fill_we_i || (st == cbcc_pkg::ST_T2A && hit_l && wr_l))
				bus.cwe_n <= bank2 ? cbcc_pkg::CWE_ODD : cbcc_pkg::CWE_EVEN; // RL20
			else
				bus.cwe_n <= cbcc_pkg::CWE_NONE;
			bus.tag_store_write_n    <= !tag_update_i; // RL21
			bus.tag_d      <= dram_phase_i ? ma_l : tag_new_i; // RL21
			bus.tag_d_oe_n <= !(tag_update_i || dram_phase_i); // RL21
			if (st == cbcc_pkg::ST_T2A)
				tag_o <= bus.tag;
		end
	end

	// Parity on the low address pins
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus.mp_oe_n <= 1'h1;
			bus.ca_lo_d <= 4'h0;
			parity_o    <= 4'h0;
		end
		else
		begin
			bus.ca_lo_d <= parity_i;
			if (st == cbcc_pkg::ST_T2A)
				bus.mp_oe_n <= !(parity_en_i && wr_l); // RL5
			else if (st == cbcc_pkg::ST_IDLE)
				bus.mp_oe_n <= 1'h1;
			if (parity_en_i && !wr_l && st != cbcc_pkg::ST_IDLE && st != cbcc_pkg::ST_T2A)
				parity_o <= bus.ca_lo; // RL5
		end
	end

	// ****************************************
	// DMA and master ownership
	// ****************************************
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus.dma_oe_n <= 1'h1;
			bus.ads_d_n  <= 1'h1;
			bus.be_d_n   <= 4'hF;
			bus.wr_d     <= 1'h0;
			bus.mio_d    <= 1'h0;
			bus.ca_hi_d  <= 9'h0;
			xd_l         <= 8'h0;
		end
		else
		begin
			bus.dma_oe_n <= !dma_grant_i; // RL24
			bus.ads_d_n  <= !(dma_grant_i && dma_start_i && !bus.dma_oe_n); // RL1
			bus.be_d_n   <= ~((at_sa_i[0] ? 4'h0 : 4'h1 << {at_sa_i[1], 1'h0})
				| (at_at_byte_high_enable_n_i ? 4'h0 : 4'h2 << {at_sa_i[1], 1'h0})); // RL2
			bus.wr_d     <= dma_wr_i; // RL14
			bus.mio_d    <= dma_mem_i; // RL11
			bus.ca_hi_d  <= dma16_i ? {xd_l, 1'h0} : {1'h0, xd_l}; // RL6
			if (dma_astb_i)
				xd_l <= xd_i; // RL6
		end
	end
endmodule // cbcc_device
`default_nettype wire

// ---- design/cbcc_pkg.sv ----
// How it works
// (RL1) CPU strobes cycle start; device strobes in DMA
// (RL2) Device drives lane enables from AT address
// (RL3) Burst ends on final indicator while acked
// (RL4) Legacy mode: burst pins carry coprocessor requests
// (RL5) Latch low address, then pins carry parity
// (RL6) DMA drives upper address from latched data
// (RL7) CPU drives data/code status per cycle type
// (RL8) Cacheable idles low, high after T1, then status
// (RL9) Legacy mode: cacheable pin is coprocessor fault
// (RL10) Local claim sampled at end of first T2
// (RL11) Memory/IO status driven by device in DMA
// (RL12) Done pin released for local device cycles
// (RL13) External done synchronised before reaching CPU
// (RL14) Write/read status driven by device in DMA
// (RL15) Even bank bit3 floats early, then follows
// (RL16) Odd bank bit3 likewise; bit2 if one bank
// (RL17) Even bank enable on bit2 low, toggles
// (RL18) Odd bank enable is even enable's inverse on read hits; both high otherwise
// (RL19) Bit-3 select early; latches DRAM address
// (RL20) Write strobe 1 even bank, 0 odd bank
// (RL21) Tag and DRAM address share eight pins
// (RL22) Burst ack first or second T2 by waits
// (RL23) Busy input high selects legacy mode
// (RL24) Drive bus lines only while owning it
package cbcc_pkg;
	localparam logic [1:0] BEAT_LAST = 2'h3;
	localparam logic [1:0] BEAT_ZERO = 2'h0;
	localparam logic [1:0] CWE_NONE  = 2'h3;
	localparam logic [1:0] CWE_EVEN  = 2'h1;
	localparam logic [1:0] CWE_ODD   = 2'h2;
	localparam logic [2:0] SYNC_ZERO = 3'h0;
	localparam logic [2:0] SYNC_ONE  = 3'h7;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_T2A   = 3'h1,
		ST_BURST = 3'h3,
		ST_WAIT  = 3'h2,
		ST_LOCAL = 3'h6
	} cbcc_state_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_T1   = 2'h1,
		H_T2   = 2'h3,
		H_HOLD = 2'h2
	} cbcc_hstate_t;
endpackage

// ---- design/cbcc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cbcc_if;
	logic        ads_n, ads_h_n, ads_d_n;
	logic        host_oe_n, dma_oe_n;
	logic [3:0]  be_n, be_h_n, be_d_n;
	logic        wr, wr_h, wr_d;
	logic        mio, mio_h, mio_d;
	logic [16:8] ca_hi, ca_hi_h, ca_hi_d;
	logic [5:2]  ca_lo, ca_lo_h, ca_lo_d;
	logic        lo_h_oe_n, mp_oe_n;
	logic [7:6]  ca_mid;
	logic        dc, burst_final_indicator_n, burst_ack_n, ken_n, local_device_claim_n, done_in_n, busy_n;
	logic        rdy_n, rdy_h_n, rdy_d_n, rdy_h_oe_n, rdy_d_oe_n;
	logic        ea3, oa3, ba_oe_n, eoe_n, ooe_n, c3s_n, tag_store_write_n;
	logic [1:0]  cwe_n;
	logic [7:0]  tag, tag_h, tag_d;
	logic        tag_h_oe_n, tag_d_oe_n;

	// Wire levels, undriven lines pulled high
	assign ads_n = !dma_oe_n ? ads_d_n : (!host_oe_n ? ads_h_n : 1'h1);
	assign be_n  = !dma_oe_n ? be_d_n : (!host_oe_n ? be_h_n : 4'hF);
	assign wr    = !dma_oe_n ? wr_d : (!host_oe_n ? wr_h : 1'h1);
	assign mio   = !dma_oe_n ? mio_d : (!host_oe_n ? mio_h : 1'h1);
	assign ca_hi = !dma_oe_n ? ca_hi_d : (!host_oe_n ? ca_hi_h : 9'h1FF);
	assign ca_lo = !mp_oe_n ? ca_lo_d : (!lo_h_oe_n ? ca_lo_h : 4'hF);
	assign rdy_n = !rdy_d_oe_n ? rdy_d_n : (!rdy_h_oe_n ? rdy_h_n : 1'h1);
	assign tag   = !tag_d_oe_n ? tag_d : (!tag_h_oe_n ? tag_h : 8'hFF);

	modport dev (
		input  ads_n, be_n, wr, mio, ca_hi, ca_lo, ca_mid, dc, burst_final_indicator_n,
		input  local_device_claim_n, rdy_n, done_in_n, busy_n, tag,
		output ads_d_n, dma_oe_n, be_d_n, wr_d, mio_d, ca_hi_d, ca_lo_d, mp_oe_n,
		output burst_ack_n, ken_n, rdy_d_n, rdy_d_oe_n, ea3, oa3, ba_oe_n,
		output eoe_n, ooe_n, c3s_n, cwe_n, tag_d, tag_d_oe_n, tag_store_write_n
	);
	modport host (
		input  rdy_n, burst_ack_n, ken_n,
		output ads_h_n, host_oe_n, be_h_n, wr_h, mio_h, ca_hi_h, ca_lo_h,
		output lo_h_oe_n, ca_mid, dc, burst_final_indicator_n, local_device_claim_n, rdy_h_n, rdy_h_oe_n,
		output done_in_n, busy_n, tag_h, tag_h_oe_n
	);
endinterface
`default_nettype wire

// ---- design/cbcc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbcc_host (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	cbcc_if.host             bus,
	input  wire logic        req_i,
	input  wire logic [16:2] req_addr_i,
	input  wire logic        req_wr_i,
	input  wire logic        req_mem_i,
	input  wire logic        req_dc_i,
	input  wire logic [3:0]  req_be_n_i,
	input  wire logic        req_burst_i,
	input  wire logic        hold_ack_i,
	input  wire logic        legacy_i,
	input  wire logic        copro_busy_n_i,
	input  wire logic        copro_req_i,
	input  wire logic        local_claim_i,
	input  wire logic        local_rdy_i,
	input  wire logic        ext_done_i,
	input  wire logic [7:0]  tag_ram_i,
	input  wire logic        tag_ram_oe_i,
	output logic             done_o,
	output logic             busy_o,
	output logic             cacheable_o
);
	cbcc_pkg::cbcc_hstate_t st;
	logic [1:0] beat;
	logic       start;
	logic       beat_ok;
	logic       fin;

	assign start   = (st == cbcc_pkg::H_IDLE) && req_i && !hold_ack_i;
	assign beat_ok = (st == cbcc_pkg::H_T2) && !legacy_i && !bus.burst_ack_n;
	assign fin     = (st == cbcc_pkg::H_T2) && (!bus.rdy_n || (beat_ok && !bus.burst_final_indicator_n)); // RL3

	// ****************************************
	// Processor cycle sequencer
	// ****************************************
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st          <= cbcc_pkg::H_IDLE;
			beat        <= cbcc_pkg::BEAT_ZERO;
			done_o      <= 1'h0;
			busy_o      <= 1'h0;
			cacheable_o <= 1'h0;
		end
		else
		begin
			done_o <= fin;
			busy_o <= start || (st == cbcc_pkg::H_T1) || (st == cbcc_pkg::H_T2 && !fin);
			unique case (st)
				cbcc_pkg::H_IDLE:
					if (hold_ack_i)
						st <= cbcc_pkg::H_HOLD;
					else if (req_i)
						st <= cbcc_pkg::H_T1;
				cbcc_pkg::H_T1:
					st <= cbcc_pkg::H_T2;
				cbcc_pkg::H_T2:
					if (fin)
						st <= cbcc_pkg::H_IDLE;
				cbcc_pkg::H_HOLD:
					if (!hold_ack_i)
						st <= cbcc_pkg::H_IDLE;
			endcase
			if (start)
				beat <= cbcc_pkg::BEAT_ZERO;
			else if (beat_ok)
				beat <= beat + 2'h1;
			if (fin)
				cacheable_o <= !bus.ken_n; // RL8
		end
	end

	// ****************************************
	// Bus pin drive
	// ****************************************
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus.host_oe_n <= 1'h0;
			bus.ads_h_n   <= 1'h1;
			bus.be_h_n    <= 4'hF;
			bus.wr_h      <= 1'h0;
			bus.mio_h     <= 1'h0;
			bus.dc        <= 1'h0;
			bus.ca_hi_h   <= 9'h0;
			bus.ca_mid    <= 2'h0;
			bus.ca_lo_h   <= 4'h0;
			bus.lo_h_oe_n <= 1'h1;
			bus.burst_final_indicator_n    <= 1'h1;
		end
		else
		begin
			bus.ads_h_n   <= !start; // RL1
			bus.lo_h_oe_n <= !start; // RL5
			if (st == cbcc_pkg::H_IDLE && hold_ack_i)
				bus.host_oe_n <= 1'h1; // RL24
			else if (st == cbcc_pkg::H_HOLD && !hold_ack_i)
				bus.host_oe_n <= 1'h0;
			if (start)
			begin
				bus.be_h_n  <= req_be_n_i;
				bus.wr_h    <= req_wr_i; // RL14
				bus.mio_h   <= req_mem_i; // RL11
				bus.dc      <= req_dc_i; // RL7
				bus.ca_hi_h <= req_addr_i[16:8];
				bus.ca_mid  <= req_addr_i[7:6];
				bus.ca_lo_h <= req_addr_i[5:2];
			end
			if (legacy_i)
				bus.burst_final_indicator_n <= copro_req_i; // RL4
			else if (start)
				bus.burst_final_indicator_n <= req_burst_i;
			else if (beat_ok && beat + 2'h1 == cbcc_pkg::BEAT_LAST)
				bus.burst_final_indicator_n <= 1'h0; // RL3
		end
	end

	// Local device, strap and tag RAM pins
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus.local_device_claim_n     <= 1'h1;
			bus.rdy_h_n    <= 1'h1;
			bus.rdy_h_oe_n <= 1'h1;
			bus.done_in_n  <= 1'h1;
			bus.busy_n     <= 1'h0;
			bus.tag_h      <= 8'h0;
			bus.tag_h_oe_n <= 1'h1;
		end
		else
		begin
			bus.local_device_claim_n     <= !local_claim_i; // RL10
			bus.rdy_h_oe_n <= !local_claim_i; // RL12
			bus.rdy_h_n    <= !local_rdy_i;
			bus.done_in_n  <= !ext_done_i;
			bus.busy_n     <= copro_busy_n_i; // RL23
			bus.tag_h      <= tag_ram_i;
			bus.tag_h_oe_n <= !tag_ram_oe_i;
		end
	end
endmodule // cbcc_host
`default_nettype wire

// ---- sim/cbcc_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbcc_props (
	input wire logic       mclk_i,
	input wire logic       nrst_i,
	input wire logic       ads_n,
	input wire logic       dma_oe_n,
	input wire logic       wr,
	input wire logic       burst_final_indicator_n,
	input wire logic       burst_ack_n,
	input wire logic       ken_n,
	input wire logic       busy_n,
	input wire logic       ba_oe_n,
	input wire logic       eoe_n,
	input wire logic       ooe_n,
	input wire logic       c3s_n,
	input wire logic [1:0] cwe_n,
	input wire logic       tag_store_write_n,
	input wire logic       tag_d_oe_n
);
	// ********************
	// Cycle timing checks
	// ********************
	logic [2:0] up_cnt;

	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);

	// Mode strap settles a few clocks after reset
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			up_cnt <= 3'h0;
		else if (up_cnt != 3'h7)
			up_cnt <= up_cnt + 3'h1;
	end

	sequence s_t1;
		!ads_n && dma_oe_n && !busy_n;
	endsequence

	property p_float; s_t1 |-> ba_oe_n ##1 ba_oe_n; endproperty
	a_float: assert property (p_float) else $error("bank pins driven too early");
	property p_sel; s_t1 |-> c3s_n ##1 !c3s_n ##1 c3s_n; endproperty
	a_sel: assert property (p_sel) else $error("bit3 select misplaced");
	property p_ken; s_t1 |-> !ken_n ##1 ken_n; endproperty
	a_ken: assert property (p_ken) else $error("cacheable not raised after T1");
	property p_last; !busy_n && !burst_ack_n && !burst_final_indicator_n |=> burst_ack_n; endproperty
	a_last: assert property (p_last) else $error("burst ack outlived final beat");
	property p_copro; up_cnt == 3'h7 && busy_n |-> burst_ack_n == $past(burst_final_indicator_n); endproperty
	a_copro: assert property (p_copro) else $error("request out does not follow request in");
	property p_inv; !busy_n && !burst_ack_n && !ba_oe_n && !wr |-> eoe_n != ooe_n; endproperty
	a_inv: assert property (p_inv) else $error("bank enables not complementary");
	property p_cwe; cwe_n != 2'h3 |-> cwe_n != 2'h0 ##1 cwe_n == 2'h3; endproperty
	a_cwe: assert property (p_cwe) else $error("bad cache write strobe");
	property p_tag; !tag_store_write_n |-> !tag_d_oe_n ##1 tag_store_write_n; endproperty
	a_tag: assert property (p_tag) else $error("tag write without tag data");

	c_burst: cover property (!burst_ack_n && !burst_final_indicator_n);
	c_cwe: cover property (cwe_n != 2'h3);
	c_tag: cover property (!tag_store_write_n);
endmodule // cbcc_props
`default_nettype wire

// ---- sim/cpu_bus_cache_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_cache_control_tb;
	logic        mclk_i, nrst_i, hit_i, cacheable_i, one_wait_i, single_bank_i, parity_en_i, copro_fault_i;
	logic        cycle_done_i, fill_we_i, tag_update_i, dram_phase_i, dma_grant_i, dma_start_i, dma16_i;
	logic        dma_wr_i, dma_mem_i, at_at_byte_high_enable_n_i, dma_astb_i, legacy_o, local_o, req_i, req_wr_i, req_mem_i;
	logic        req_dc_i, req_burst_i, hold_ack_i, copro_busy_n_i, copro_req_i, local_claim_i, local_rdy_i;
	logic        ext_done_i, tag_ram_oe_i, done_o, busy_o, cacheable_o, kn, fl;
	logic [1:0]  at_sa_i, cw;
	logic [3:0]  parity_i, addr_lo_o, parity_o, req_be_n_i, mp, be;
	logic [7:0]  tag_new_i, dram_addr_i, xd_i, tag_o, tag_ram_i;
	logic [16:2] req_addr_i, ad;
	int          bad_count, checks_done, seed, t_ads, t_burst_ack, t_rdy, beats, mode, wt;

	cbcc_if cbcc_if_i ();
	cbcc_device cbcc_device_i (.mclk_i, .nrst_i, .bus(cbcc_if_i.dev), .hit_i, .cacheable_i, .one_wait_i,
		.single_bank_i, .parity_en_i, .parity_i, .copro_fault_i, .cycle_done_i, .fill_we_i, .tag_update_i,
		.tag_new_i, .dram_phase_i, .dram_addr_i, .dma_grant_i, .dma_start_i, .dma16_i, .dma_wr_i, .dma_mem_i,
		.at_sa_i, .at_at_byte_high_enable_n_i, .xd_i, .dma_astb_i, .addr_lo_o, .tag_o, .parity_o, .legacy_o, .local_o);
	cbcc_host cbcc_host_i (.mclk_i, .nrst_i, .bus(cbcc_if_i.host), .req_i, .req_addr_i, .req_wr_i, .req_mem_i,
		.req_dc_i, .req_be_n_i, .req_burst_i, .hold_ack_i, .legacy_i(legacy_o), .copro_busy_n_i, .copro_req_i,
		.local_claim_i, .local_rdy_i, .ext_done_i, .tag_ram_i, .tag_ram_oe_i, .done_o, .busy_o, .cacheable_o);
	cbcc_props cbcc_props_i (.mclk_i, .nrst_i, .ads_n(cbcc_if_i.ads_n), .dma_oe_n(cbcc_if_i.dma_oe_n),
		.wr(cbcc_if_i.wr), .burst_final_indicator_n(cbcc_if_i.burst_final_indicator_n), .burst_ack_n(cbcc_if_i.burst_ack_n), .ken_n(cbcc_if_i.ken_n),
		.busy_n(cbcc_if_i.busy_n), .ba_oe_n(cbcc_if_i.ba_oe_n), .eoe_n(cbcc_if_i.eoe_n),
		.ooe_n(cbcc_if_i.ooe_n), .c3s_n(cbcc_if_i.c3s_n), .cwe_n(cbcc_if_i.cwe_n),
		.tag_store_write_n(cbcc_if_i.tag_store_write_n), .tag_d_oe_n(cbcc_if_i.tag_d_oe_n));

	always #2 mclk_i = !mclk_i;

	// ********************
	// Tasks
	// ********************
	task automatic chk(input string what, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic rst(input logic legacy);
		nrst_i = 1'h0;
		copro_busy_n_i = legacy;
		repeat (2) @(negedge mclk_i);
		nrst_i = 1'h1;
		repeat (6) @(negedge mclk_i);
	endtask

	// One processor cycle, recording when each answer shows
	task automatic run(input logic [16:2] a, input logic w, b);
		int n;
		t_ads = -1;
		t_burst_ack = -1;
		t_rdy = -1;
		beats = 0;
		cw = 2'h3;
		fl = 1'h0;
		mp = 4'hX;
		@(negedge mclk_i);
		{req_addr_i, req_wr_i, req_burst_i, req_i} = {a, w, b, 1'h1};
		{req_dc_i, req_be_n_i, dram_addr_i} = 13'($random(seed));
		@(negedge mclk_i);
		req_i = 1'h0;
		for (n = 0; n < 60 && done_o !== 1'h1; n++)
		begin
			cycle_done_i = (mode == 1 && n == 4);
			ext_done_i = (mode == 2 && n >= 4);
			if (cbcc_if_i.ads_n === 1'h0 && t_ads < 0)
				t_ads = n;
			if (cbcc_if_i.rdy_n === 1'h0 && t_rdy < 0)
				t_rdy = n;
			if (cbcc_if_i.rdy_d_oe_n === 1'h1 && n > 1)
				fl = 1'h1;
			if (cbcc_if_i.cwe_n !== 2'h3 && cw === 2'h3)
				cw = cbcc_if_i.cwe_n;
			if (cbcc_if_i.mp_oe_n === 1'h0)
				mp = cbcc_if_i.ca_lo;
			if (cbcc_if_i.burst_ack_n === 1'h0)
			begin
				if (t_burst_ack < 0)
					t_burst_ack = n;
				kn = cbcc_if_i.ken_n;
				if (cbcc_if_i.ba_oe_n === 1'h0)
				begin
					chk("bank bit3", a[3] ^ beats[1], cbcc_if_i.ea3);
					chk("even enable", a[2] ^ beats[0], cbcc_if_i.eoe_n);
					chk("odd bank bit", single_bank_i ? a[2] ^ beats[0] : a[3] ^ beats[1], cbcc_if_i.oa3);
				end
				beats++;
			end
			@(negedge mclk_i);
		end
		{cycle_done_i, ext_done_i} = 2'h0;
		chk("cycle end", 1'h1, done_o);
		chk("host idle", 1'h0, busy_o);
		chk("data code", req_dc_i, cbcc_if_i.dc);
	endtask

	// ********************
	// Main sequence
	// ********************
	initial
	begin
		{mclk_i, hit_i, cacheable_i, one_wait_i, single_bank_i, copro_fault_i, cycle_done_i, fill_we_i} = '0;
		{tag_update_i, dram_phase_i, dma_grant_i, dma_start_i, dma16_i, dma_wr_i, dma_mem_i, dma_astb_i} = '0;
		{req_i, req_wr_i, req_dc_i, req_burst_i, hold_ack_i, copro_req_i, local_claim_i, local_rdy_i} = '0;
		{ext_done_i, parity_i, tag_new_i, dram_addr_i, xd_i, tag_ram_i, req_addr_i, req_be_n_i, at_sa_i} = '0;
		{nrst_i, at_at_byte_high_enable_n_i, parity_en_i, tag_ram_oe_i, req_mem_i, hit_i} = 6'h1F;
		seed = 32'hF2FE;
		rst(1'h0);
		chk("legacy", 1'h0, legacy_o);
		for (int i = 0; i < 6; i++)
		begin
			{one_wait_i, single_bank_i, cacheable_i, tag_ram_i} = {i[0], i[1], 9'($random(seed))};
			run(15'($random(seed)), 1'h0, 1'h1);
			chk("ack delay", 16'(1 + one_wait_i), 16'(t_burst_ack - t_ads));
			chk("beats", 16'h4, 16'(beats));
			chk("cacheable", !cacheable_i, kn);
			chk("tag read", tag_ram_i, tag_o);
			chk("cacheable out", cacheable_i, cacheable_o);
		end
		{one_wait_i, mode} = {1'h0, 32'd1};
		for (int i = 0; i < 2; i++)
		begin
			{parity_i, ad} = 19'($random(seed));
			ad[2] = i[0];
			run(ad, 1'h1, 1'h0);
			chk("write strobe", ad[2] ? 2'h2 : 2'h1, cw);
			chk("parity", parity_i, mp);
			chk("low address", ad[5:2], addr_lo_o);
			chk("quick done", 1'h0, t_rdy >= 7);
		end
		{hit_i, req_mem_i, mode} = {2'h0, 32'd2};
		run(ad, 1'h0, 1'h0);
		chk("synced done", 1'h1, t_rdy >= 7);
		{req_mem_i, mode, local_claim_i, local_rdy_i} = {1'h1, 32'd0, 2'h3};
		run(ad, 1'h0, 1'h0);
		chk("local seen", 1'h1, local_o);
		chk("done released", 1'h1, fl);
		{local_claim_i, local_rdy_i, tag_update_i, tag_new_i} = {3'h1, 8'($random(seed))};
		@(negedge mclk_i);
		tag_update_i = 1'h0;
		for (wt = 0; wt < 3 && cbcc_if_i.tag_store_write_n !== 1'h0; wt++)
			@(negedge mclk_i);
		chk("tag write", tag_new_i, cbcc_if_i.tag);
		{dma_grant_i, hold_ack_i} = 2'h3;
		repeat (3) @(negedge mclk_i);
		for (int k = 0; k < 8; k++)
		begin
			{at_sa_i, at_at_byte_high_enable_n_i, dma16_i, dma_wr_i, dma_mem_i, xd_i} = {3'(k), 11'($random(seed))};
			dma_astb_i = 1'h1;
			@(negedge mclk_i);
			{dma_astb_i, dma_start_i} = 2'h1;
			@(negedge mclk_i);
			dma_start_i = 1'h0;
			for (wt = 0; wt < 4 && cbcc_if_i.ads_n !== 1'h0; wt++)
				@(negedge mclk_i);
			be = 4'hF;
			be[{at_sa_i[1], 1'h0}] = at_sa_i[0];
			be[{at_sa_i[1], 1'h1}] = at_at_byte_high_enable_n_i;
			chk("dma strobe", 1'h0, cbcc_if_i.ads_n);
			chk("lanes", be, cbcc_if_i.be_n);
			chk("upper address", dma16_i ? {xd_i, 1'h0} : {1'h0, xd_i}, cbcc_if_i.ca_hi);
			chk("status", {dma_wr_i, dma_mem_i}, {cbcc_if_i.wr, cbcc_if_i.mio});
			@(negedge mclk_i);
		end
		{dma_grant_i, hold_ack_i} = 2'h0;
		repeat (3) @(negedge mclk_i);
		chk("bus released", 1'h1, cbcc_if_i.dma_oe_n);
		rst(1'h1);
		chk("legacy", 1'h1, legacy_o);
		for (int i = 0; i < 8; i++)
		begin
			{copro_req_i, copro_fault_i} = 2'($random(seed));
			repeat (3) @(negedge mclk_i);
			chk("fault", !copro_fault_i, cbcc_if_i.ken_n);
		end
		complete_run;
	end

	initial
	begin
		#20000;
		bad_count++;
		complete_run;
	end
endmodule // cpu_bus_cache_control_tb
`default_nettype wire
